// file: logic/pcac_top.sv
// count-function system register bank with access-authority gate
// assumes the core presents one move instruction per valid cycle on the core clock
`timescale 1ns/1ps
module pcac_top
  import pcac_pkg::*;
#(
  parameter int NUM_CH = 8
) (
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        req_valid_i,
  input  wire logic        req_write_i,
  input  wire logic [4:0]  req_sysreg_number_i,
  input  wire logic [4:0]  req_sysreg_selection_i,
  input  wire logic [31:0] req_wdata_i,
  input  wire logic        auth_supervisor_i,
  input  wire logic        auth_guest_i,
  input  wire logic        virtualization_enable_i,
  output logic             rsp_valid_o,
  output logic [31:0]      rsp_rdata_o,
  output logic             rsp_privileged_instr_exception_o,
  output logic             rsp_undefined_o
);

  // ------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------
  if (NUM_CH < 1 || NUM_CH > PCAC_MAX_CH) begin : g_bad_num_ch
    $error("pcac_top: NUM_CH must lie between 1 and 8");
  end

  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  logic [31:0] ts_low_reg;
  logic [31:0] ts_high_reg;
  logic [31:0] ts_ctrl_reg;
  logic [31:0] user_perf_access_enable_reg;
  logic [31:0] guest_perf_access_enable_reg;
  logic [31:0] ch_ctrl_reg  [NUM_CH];
  logic [31:0] ch_count_reg [NUM_CH];
  logic [31:0] ch_sub_reg   [NUM_CH];
  logic [31:0] rdata_next;
  logic        do_write;
  logic        denied;

  pcac_dec_if dec ();

  assign dec.regnum   = req_sysreg_number_i;
  assign dec.sysreg_selection    = req_sysreg_selection_i;
  assign dec.write    = req_write_i;
  assign dec.sup      = auth_supervisor_i;
  assign dec.guest    = auth_guest_i;
  assign dec.virtualization_enable      = virtualization_enable_i;
  assign dec.user_en  = user_perf_access_enable_reg[PCAC_USER_EN_BIT];
  assign dec.guest_en = guest_perf_access_enable_reg[7:0];

  pcac_auth_check #(
    .NUM_CH (NUM_CH)
  ) u_check (
    .bus (dec.checker_end)
  );

  // ------------------------------------------------------------
  // write gating
  // ------------------------------------------------------------
  // a refused store never reaches storage
  assign do_write = req_valid_i && req_write_i && dec.hit && dec.allowed;
  assign denied   = req_valid_i && dec.hit && !dec.allowed;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ts_low_reg  <= PCAC_REG_RESET;
      ts_high_reg <= PCAC_REG_RESET;
      ts_ctrl_reg <= PCAC_REG_RESET;
    end else if (do_write) begin
      if (dec.target == PCAC_TGT_TS_LOW) begin
        ts_low_reg <= req_wdata_i;
      end
      if (dec.target == PCAC_TGT_TS_HIGH) begin
        ts_high_reg <= req_wdata_i;
      end
      if (dec.target == PCAC_TGT_TS_CTRL) begin
        ts_ctrl_reg <= req_wdata_i;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      user_perf_access_enable_reg  <= PCAC_REG_RESET;
      guest_perf_access_enable_reg <= PCAC_GM_RESET;
    end else if (do_write) begin
      if (dec.target == PCAC_TGT_USER_EN) begin
        user_perf_access_enable_reg <= req_wdata_i;
      end
      if (dec.target == PCAC_TGT_GUEST_EN) begin
        // reserved bits dropped at write so they can never read back
        guest_perf_access_enable_reg <= req_wdata_i & PCAC_GM_MASK;
      end
    end
  end

  // counting itself lives elsewhere; these hold software values only
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      for (int i = 0; i < NUM_CH; i++) begin
        ch_ctrl_reg[i]  <= PCAC_REG_RESET;
        ch_count_reg[i] <= PCAC_REG_RESET;
        ch_sub_reg[i]   <= PCAC_REG_RESET;
      end
    end else if (do_write) begin
      if (dec.target == PCAC_TGT_CH_CTRL) begin
        ch_ctrl_reg[dec.chan] <= req_wdata_i;
      end
      if (dec.target == PCAC_TGT_CH_COUNT) begin
        ch_count_reg[dec.chan] <= req_wdata_i;
      end
      if (dec.target == PCAC_TGT_CH_SUB) begin
        ch_sub_reg[dec.chan] <= req_wdata_i;
      end
    end
  end

  // ------------------------------------------------------------
  // read path and response
  // ------------------------------------------------------------
  // refused and undefined loads return zero so nothing leaks
  always_comb begin
    rdata_next = PCAC_RD_ZERO;
    if (req_valid_i && !req_write_i && dec.hit && dec.allowed) begin
      unique case (dec.target)
        PCAC_TGT_TS_LOW:   rdata_next = ts_low_reg;
        PCAC_TGT_TS_HIGH:  rdata_next = ts_high_reg;
        PCAC_TGT_TS_CTRL:  rdata_next = ts_ctrl_reg;
        PCAC_TGT_USER_EN:  rdata_next = user_perf_access_enable_reg;
        PCAC_TGT_GUEST_EN: rdata_next = guest_perf_access_enable_reg;
        PCAC_TGT_CH_CTRL:  rdata_next = ch_ctrl_reg[dec.chan];
        PCAC_TGT_CH_COUNT: rdata_next = ch_count_reg[dec.chan];
        PCAC_TGT_CH_SUB:   rdata_next = ch_sub_reg[dec.chan];
        PCAC_TGT_NONE:     rdata_next = PCAC_RD_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rsp_valid_o                      <= 1'b0;
      rsp_rdata_o                      <= PCAC_RD_ZERO;
      rsp_privileged_instr_exception_o <= 1'b0;
      rsp_undefined_o                  <= 1'b0;
    end else begin
      rsp_valid_o                      <= req_valid_i;
      rsp_rdata_o                      <= rdata_next;
      rsp_privileged_instr_exception_o <= denied;
      rsp_undefined_o                  <= req_valid_i && dec.undef;
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  a_resp_follows_req: assert property (req_valid_i |=> rsp_valid_o ##1 (rsp_valid_o == $past(req_valid_i)))
    else $error("response does not follow request by one cycle");

  a_ts_write_guest: assert property (req_valid_i && req_write_i && virtualization_enable_i && auth_guest_i &&
      req_sysreg_selection_i == PCAC_SEL_TS && req_sysreg_number_i == PCAC_NUM_TSL
      |=> rsp_privileged_instr_exception_o && $stable(ts_low_reg))
    else $error("guest write to timestamp low was not refused");

  a_ts_user_read: assert property (req_valid_i && !req_write_i && !auth_supervisor_i &&
      req_sysreg_selection_i == PCAC_SEL_TS && req_sysreg_number_i == PCAC_NUM_TSH
      |=> !rsp_privileged_instr_exception_o && rsp_rdata_o == $past(ts_high_reg))
    else $error("user read of timestamp high refused or wrong");

  a_umc_needs_sv: assert property (req_valid_i && !auth_supervisor_i &&
      req_sysreg_selection_i == PCAC_SEL_TS && req_sysreg_number_i == PCAC_NUM_UMC
      |=> rsp_privileged_instr_exception_o)
    else $error("user access to user enable not refused");

  a_gm_guest_write: assert property (req_valid_i && req_write_i && virtualization_enable_i &&
      auth_guest_i && req_sysreg_selection_i == PCAC_SEL_TS && req_sysreg_number_i == PCAC_NUM_GMC
      |=> rsp_privileged_instr_exception_o && $stable(guest_perf_access_enable_reg))
    else $error("guest changed the guest enable");

  a_user_chan_open: assert property (req_valid_i && !auth_supervisor_i && !virtualization_enable_i &&
      user_perf_access_enable_reg[PCAC_USER_EN_BIT] && req_sysreg_selection_i == PCAC_SEL_PMSUB &&
      req_sysreg_number_i == PCAC_SUB_BASE |=> !rsp_privileged_instr_exception_o && !rsp_undefined_o)
    else $error("user enable did not open channel access");

  a_guest_chan_block: assert property (req_valid_i && virtualization_enable_i && auth_guest_i &&
      req_sysreg_selection_i == PCAC_SEL_PMCH && req_sysreg_number_i == PCAC_COUNT_BASE &&
      !guest_perf_access_enable_reg[0] |=> rsp_privileged_instr_exception_o ##1 1'b1)
    else $error("guest access to blocked channel not refused");

  a_gm_undef_off: assert property (req_valid_i && !virtualization_enable_i &&
      req_sysreg_selection_i == PCAC_SEL_TS && req_sysreg_number_i == PCAC_NUM_GMC
      |=> rsp_undefined_o && !rsp_privileged_instr_exception_o && rsp_rdata_o == PCAC_RD_ZERO)
    else $error("guest enable not undefined with virtualization off");

  a_gm_reserved_zero: assert property ((guest_perf_access_enable_reg & ~PCAC_GM_MASK) == PCAC_RD_ZERO)
    else $error("reserved guest enable bits set");

  a_gm_after_reset: assert property (disable iff (1'b0) $fell(reset_i) |->
      guest_perf_access_enable_reg == PCAC_GM_RESET)
    else $error("guest enable not zero after reset");

  a_denied_no_store: assert property (denied && req_write_i && dec.target == PCAC_TGT_USER_EN
      |=> $stable(user_perf_access_enable_reg))
    else $error("refused store changed the user enable");

  // ------------------------------------------------------------
  // refusal, data and idle assertions
  // ------------------------------------------------------------
  a_exc_undef_excl: assert property (!(rsp_privileged_instr_exception_o && rsp_undefined_o))
    else $error("exception and undefined raised together");

  a_idle_quiet: assert property (!req_valid_i |=> !rsp_valid_o && !rsp_privileged_instr_exception_o &&
      !rsp_undefined_o && rsp_rdata_o == PCAC_RD_ZERO)
    else $error("response raised without a request");

  a_tsc_user_refused: assert property (req_valid_i && !auth_supervisor_i &&
      req_sysreg_selection_i == PCAC_SEL_TS && req_sysreg_number_i == PCAC_NUM_TSC
      |=> rsp_privileged_instr_exception_o && rsp_rdata_o == PCAC_RD_ZERO && $stable(ts_ctrl_reg))
    else $error("user access to timestamp control not refused");

  a_tsc_guest_refused: assert property (req_valid_i && virtualization_enable_i && auth_guest_i &&
      req_sysreg_selection_i == PCAC_SEL_TS && req_sysreg_number_i == PCAC_NUM_TSC
      |=> rsp_privileged_instr_exception_o)
    else $error("guest access to timestamp control not refused");

  a_ts_sv_write: assert property (req_valid_i && req_write_i && !virtualization_enable_i &&
      auth_supervisor_i && req_sysreg_selection_i == PCAC_SEL_TS && req_sysreg_number_i == PCAC_NUM_TSL
      |=> !rsp_privileged_instr_exception_o && ts_low_reg == $past(req_wdata_i))
    else $error("supervisor write to timestamp low lost");

  a_gm_host_write: assert property (req_valid_i && req_write_i && virtualization_enable_i &&
      auth_supervisor_i && !auth_guest_i &&
      req_sysreg_selection_i == PCAC_SEL_TS && req_sysreg_number_i == PCAC_NUM_GMC
      |=> guest_perf_access_enable_reg == ($past(req_wdata_i) & PCAC_GM_MASK))
    else $error("host write to guest enable not stored as masked");

  a_umc_guest_sv: assert property (req_valid_i && auth_supervisor_i &&
      req_sysreg_selection_i == PCAC_SEL_TS && req_sysreg_number_i == PCAC_NUM_UMC
      |=> !rsp_privileged_instr_exception_o && !rsp_undefined_o)
    else $error("supervisor access to user enable refused");

  a_guest_chan_open: assert property (req_valid_i && virtualization_enable_i && auth_guest_i &&
      auth_supervisor_i && guest_perf_access_enable_reg[0] &&
      req_sysreg_selection_i == PCAC_SEL_PMSUB && req_sysreg_number_i == PCAC_SUB_BASE
      |=> !rsp_privileged_instr_exception_o && !rsp_undefined_o)
    else $error("guest access to open channel refused");

  a_user_chan_shut: assert property (req_valid_i && !auth_supervisor_i &&
      !user_perf_access_enable_reg[PCAC_USER_EN_BIT] &&
      req_sysreg_selection_i == PCAC_SEL_PMCH && req_sysreg_number_i == PCAC_CTRL_BASE
      |=> rsp_privileged_instr_exception_o && rsp_rdata_o == PCAC_RD_ZERO)
    else $error("user access to channel without user enable not refused");

  a_chan_store_refused: assert property (denied && req_write_i &&
      req_sysreg_selection_i == PCAC_SEL_PMCH && req_sysreg_number_i == PCAC_COUNT_BASE
      |=> $stable(ch_count_reg[0]))
    else $error("refused store changed channel count");

  a_chan_read_data: assert property (req_valid_i && !req_write_i && auth_supervisor_i && !auth_guest_i &&
      req_sysreg_selection_i == PCAC_SEL_PMCH && req_sysreg_number_i == PCAC_COUNT_BASE
      |=> rsp_rdata_o == $past(ch_count_reg[0]))
    else $error("channel count read returned wrong data");

  a_bad_sel_undef: assert property (req_valid_i && req_sysreg_selection_i != PCAC_SEL_TS &&
      req_sysreg_selection_i != PCAC_SEL_PMCH && req_sysreg_selection_i != PCAC_SEL_PMSUB
      |=> rsp_undefined_o && !rsp_privileged_instr_exception_o)
    else $error("foreign selection not reported undefined");

  c_user_chan_read: cover property (req_valid_i && !req_write_i && !auth_supervisor_i && dec.hit && dec.allowed &&
      dec.target == PCAC_TGT_CH_COUNT);
  c_guest_blocked: cover property (denied && auth_guest_i && dec.target == PCAC_TGT_CH_CTRL);
  c_gm_written: cover property (do_write && dec.target == PCAC_TGT_GUEST_EN);
  c_undef_seen: cover property (rsp_undefined_o);
  c_ts_user_read: cover property (req_valid_i && !req_write_i && !auth_supervisor_i &&
      dec.target == PCAC_TGT_TS_LOW);

endmodule

// file: logic/pcac_pkg.sv
// constants, target enumeration and bank decode for the count-function access gate
// assumes one core clock domain; all users import the whole package
package pcac_pkg;

  // ------------------------------------------------------------
  // system register addressing
  // ------------------------------------------------------------
  localparam logic [4:0] PCAC_SEL_TS     = 5'h0B;
  localparam logic [4:0] PCAC_SEL_PMCH   = 5'h0E;
  localparam logic [4:0] PCAC_SEL_PMSUB  = 5'h0F;
  localparam logic [4:0] PCAC_NUM_TSL    = 5'h00;
  localparam logic [4:0] PCAC_NUM_TSH    = 5'h01;
  localparam logic [4:0] PCAC_NUM_TSC    = 5'h02;
  localparam logic [4:0] PCAC_NUM_UMC    = 5'h08;
  localparam logic [4:0] PCAC_NUM_GMC    = 5'h09;
  localparam logic [4:0] PCAC_CTRL_BASE  = 5'h00;
  localparam logic [4:0] PCAC_COUNT_BASE = 5'h10;
  localparam logic [4:0] PCAC_SUB_BASE   = 5'h00;

  // ------------------------------------------------------------
  // widths, fields and reset values
  // ------------------------------------------------------------
  localparam int          PCAC_MAX_CH      = 8;
  localparam int          PCAC_USER_EN_BIT = 0;
  localparam logic [31:0] PCAC_GM_MASK     = 32'h0000_00FF;
  localparam logic [31:0] PCAC_GM_RESET    = 32'h0000_0000;
  localparam logic [31:0] PCAC_REG_RESET   = 32'h0000_0000;
  localparam logic [31:0] PCAC_RD_ZERO     = 32'h0000_0000;

  typedef enum logic [3:0] {
    PCAC_TGT_NONE,
    PCAC_TGT_TS_LOW,
    PCAC_TGT_TS_HIGH,
    PCAC_TGT_TS_CTRL,
    PCAC_TGT_USER_EN,
    PCAC_TGT_GUEST_EN,
    PCAC_TGT_CH_CTRL,
    PCAC_TGT_CH_COUNT,
    PCAC_TGT_CH_SUB
  } pcac_target_type;

  // number falls inside a bank of count registers starting at base
  function automatic logic pcac_in_bank(input logic [4:0] num,
                                        input logic [4:0] base,
                                        input logic [4:0] count);
    return ({1'b0, num} >= {1'b0, base}) && ({1'b0, num} < ({1'b0, base} + {1'b0, count}));
  endfunction

endpackage

// file: logic/pcac_dec_if.sv
// decode request and verdict between the access gate top and its checker
// assumes both ends sit on the same core clock
`timescale 1ns/1ps
interface pcac_dec_if;
  import pcac_pkg::*;

  logic [4:0]      regnum;
  logic [4:0]      sysreg_selection;
  logic            write;
  logic            sup;
  logic            guest;
  logic            virtualization_enable;
  logic            user_en;
  logic [7:0]      guest_en;
  logic            hit;
  logic            undef;
  logic            allowed;
  pcac_target_type target;
  logic [2:0]      chan;

  modport checker_end (
    input  regnum, sysreg_selection, write, sup, guest, virtualization_enable, user_en, guest_en,
    output hit, undef, allowed, target, chan
  );
  modport top_end (
    output regnum, sysreg_selection, write, sup, guest, virtualization_enable, user_en, guest_en,
    input  hit, undef, allowed, target, chan
  );
endinterface

// file: logic/pcac_auth_check.sv
// combinational decode of (number, selection) and authority verdict
// assumes the top drives every request field through the interface
`timescale 1ns/1ps
module pcac_auth_check
  import pcac_pkg::*;
#(
  parameter int NUM_CH = 8
) (
  pcac_dec_if.checker_end bus
);

  logic hv_auth;
  logic chan_ok;
  logic [4:0] ch_count;

  assign ch_count = 5'(NUM_CH);
  // host supervisor only; guest supervisor never reaches hypervisor level
  assign hv_auth  = bus.sup && !bus.guest;

  // guest access needs its channel bit, host user needs the user enable
  always_comb begin
    if (bus.virtualization_enable) begin
      if (bus.guest) begin
        chan_ok = bus.guest_en[bus.chan] && (bus.sup || bus.user_en);
      end else begin
        chan_ok = bus.sup || bus.user_en;
      end
    end else begin
      chan_ok = bus.sup || bus.user_en;
    end
  end

  always_comb begin
    bus.hit     = 1'b0;
    bus.undef   = 1'b0;
    bus.allowed = 1'b0;
    bus.target  = PCAC_TGT_NONE;
    bus.chan    = bus.regnum[2:0];
    // selection picks the group, number the register
    unique case (bus.sysreg_selection)
      PCAC_SEL_TS: begin
        if (bus.regnum == PCAC_NUM_TSL || bus.regnum == PCAC_NUM_TSH) begin
          bus.hit     = 1'b1;
          bus.target  = (bus.regnum == PCAC_NUM_TSL) ? PCAC_TGT_TS_LOW : PCAC_TGT_TS_HIGH;
          // reads open to every level, writes need supervisor, host supervisor when virtualization is on
          bus.allowed = !bus.write || (bus.virtualization_enable ? hv_auth : bus.sup);
        end else if (bus.regnum == PCAC_NUM_TSC) begin
          bus.hit     = 1'b1;
          bus.target  = PCAC_TGT_TS_CTRL;
          bus.allowed = bus.virtualization_enable ? hv_auth : bus.sup;
        end else if (bus.regnum == PCAC_NUM_UMC) begin
          bus.hit     = 1'b1;
          bus.target  = PCAC_TGT_USER_EN;
          bus.allowed = bus.sup;
        end else if (bus.regnum == PCAC_NUM_GMC) begin
          if (bus.virtualization_enable) begin
            bus.hit     = 1'b1;
            bus.target  = PCAC_TGT_GUEST_EN;
            bus.allowed = hv_auth;
          end else begin
            bus.undef = 1'b1;
          end
        end else begin
          bus.undef = 1'b1;
        end
      end
      PCAC_SEL_PMCH: begin
        if (pcac_in_bank(bus.regnum, PCAC_CTRL_BASE, ch_count)) begin
          bus.hit     = 1'b1;
          bus.target  = PCAC_TGT_CH_CTRL;
          bus.allowed = chan_ok;
        end else if (pcac_in_bank(bus.regnum, PCAC_COUNT_BASE, ch_count)) begin
          bus.hit     = 1'b1;
          bus.target  = PCAC_TGT_CH_COUNT;
          bus.allowed = chan_ok;
        end else begin
          bus.undef = 1'b1;
        end
      end
      PCAC_SEL_PMSUB: begin
        if (pcac_in_bank(bus.regnum, PCAC_SUB_BASE, ch_count)) begin
          bus.hit     = 1'b1;
          bus.target  = PCAC_TGT_CH_SUB;
          bus.allowed = chan_ok;
        end else begin
          bus.undef = 1'b1;
        end
      end
      default: begin
        bus.undef = 1'b1;
      end
    endcase
  end

endmodule

// file: tb/pcac_core_model.sv
// core-side model that issues system register move instructions to the access gate
// assumes the bench calls drive once per cycle, only after reset is released
`timescale 1ns/1ps
module pcac_core_model (
  input  wire logic        clk_i,
  output logic             req_valid_o,
  output logic             req_write_o,
  output logic [4:0]       req_sysreg_number_o,
  output logic [4:0]       req_sysreg_selection_o,
  output logic [31:0]      req_wdata_o,
  output logic             auth_supervisor_o,
  output logic             auth_guest_o,
  output logic             virtualization_enable_o
);
  initial begin
    req_valid_o             = 1'b0;
    req_write_o             = 1'b0;
    req_sysreg_number_o     = 5'h00;
    req_sysreg_selection_o  = 5'h00;
    req_wdata_o             = 32'h0000_0000;
    auth_supervisor_o       = 1'b0;
    auth_guest_o            = 1'b0;
    virtualization_enable_o = 1'b0;
  end

  // ------------------------------------------------------------
  // one instruction per call, launched on the falling edge
  // ------------------------------------------------------------
  task automatic drive(input logic v, input logic w, input logic [4:0] num, input logic [4:0] sel,
                       input logic [31:0] wd, input logic sv, input logic g, input logic virtualization_enable);
    @(negedge clk_i);
    req_valid_o             <= v;
    auth_supervisor_o       <= sv;
    auth_guest_o            <= g;
    virtualization_enable_o <= virtualization_enable;
    if (v) begin
      // move instruction addressed by number and selection
      req_write_o            <= w;
      req_sysreg_number_o    <= num;
      req_sysreg_selection_o <= sel;
      req_wdata_o            <= wd;
    end else begin
      // idle: scramble the lines so nothing may lean on stale values
      req_write_o            <= ~req_write_o;
      req_sysreg_number_o    <= ~req_sysreg_number_o;
      req_sysreg_selection_o <= ~req_sysreg_selection_o;
      req_wdata_o            <= ~req_wdata_o;
    end
  endtask
endmodule

// file: tb/perf_counter_access_control_tb.sv
// self-checking bench for the count-function access gate
// assumes a single 250 MHz core clock and one-cycle response latency
`timescale 1ns/1ps
module perf_counter_access_control_tb;
  import pcac_pkg::*;

  logic        clk_i;
  logic        reset_i;
  logic        valid, wr, sup, gst, virtualization_enable;
  logic [4:0]  num, sel;
  logic [31:0] wdata;
  logic        rsp_valid, rsp_exc, rsp_undef;
  logic [31:0] rsp_rdata;
  logic [31:0] shadow [0:1023];
  logic        exp_valid, exp_exc, exp_undef, have_exp;
  logic [31:0] exp_rdata;
  logic [31:0] seed, r;
  logic [4:0]  rnum, rsel;
  logic [4:0]  ts_nums [0:7];
  int          num_errors, tests_run, cycles, i;

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  pcac_core_model core (
    .clk_i                   (clk_i),
    .req_valid_o             (valid),
    .req_write_o             (wr),
    .req_sysreg_number_o     (num),
    .req_sysreg_selection_o  (sel),
    .req_wdata_o             (wdata),
    .auth_supervisor_o       (sup),
    .auth_guest_o            (gst),
    .virtualization_enable_o (virtualization_enable)
  );

  pcac_top #(.NUM_CH(8)) dut (
    .clk_i                            (clk_i),
    .reset_i                          (reset_i),
    .req_valid_i                      (valid),
    .req_write_i                      (wr),
    .req_sysreg_number_i              (num),
    .req_sysreg_selection_i           (sel),
    .req_wdata_i                      (wdata),
    .auth_supervisor_i                (sup),
    .auth_guest_i                     (gst),
    .virtualization_enable_i          (virtualization_enable),
    .rsp_valid_o                      (rsp_valid),
    .rsp_rdata_o                      (rsp_rdata),
    .rsp_privileged_instr_exception_o (rsp_exc),
    .rsp_undefined_o                  (rsp_undef)
  );

  // ------------------------------------------------------------
  // expectation: returns {undefined, exception}
  // ------------------------------------------------------------
  function automatic logic [1:0] expect_verdict(input logic [4:0] n, input logic [4:0] s, input logic w,
                                                input logic sv, input logic g, input logic hv_on,
                                                input logic ue, input logic [7:0] ge);
    logic hv;
    logic ok;
    hv = sv && !g;
    if (s == 5'h0B && (n == 5'h00 || n == 5'h01)) return {1'b0, w && !(hv_on ? hv : sv)};
    if (s == 5'h0B && n == 5'h02) return {1'b0, !(hv_on ? hv : sv)};
    if (s == 5'h0B && n == 5'h08) return {1'b0, !sv};
    if (s == 5'h0B && n == 5'h09) return hv_on ? {1'b0, !hv} : 2'b10;
    if ((s == 5'h0E && (n < 5'h08 || (n >= 5'h10 && n < 5'h18))) || (s == 5'h0F && n < 5'h08)) begin
      ok = sv || ue;
      if (hv_on && g) ok = ok && ge[n[2:0]];
      return {1'b0, !ok};
    end
    return 2'b10;
  endfunction

  // ------------------------------------------------------------
  // compare tasks and closing report
  // ------------------------------------------------------------
  task automatic check_flag(input string what, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic check_data(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic print_verdict;
    if (num_errors == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // issue one cycle, check the answer to the previous one, then predict this one
  task automatic step(input logic v, input logic w, input logic [4:0] n, input logic [4:0] s,
                      input logic [31:0] wd, input logic sv, input logic g, input logic hv_on);
    logic [1:0] vd;
    logic [9:0] a;
    a = {s, n};
    core.drive(v, w, n, s, wd, sv, g, hv_on);
    if (have_exp) begin
      check_flag("rsp_valid", exp_valid, rsp_valid);
      check_flag("exception", exp_exc, rsp_exc);
      check_flag("undefined", exp_undef, rsp_undef);
      check_data("rdata", exp_rdata, rsp_rdata);
    end
    vd = expect_verdict(n, s, w, sv, g, hv_on, shadow[{5'h0B, 5'h08}][0], shadow[{5'h0B, 5'h09}][7:0]);
    exp_valid = v;
    exp_undef = v & vd[1];
    exp_exc   = v & vd[0];
    exp_rdata = (v && !w && vd == 2'b00) ? shadow[a] : 32'h0000_0000;
    if (v && w && vd == 2'b00) shadow[a] = (a == {5'h0B, 5'h09}) ? (wd & 32'h0000_00FF) : wd;
    have_exp = 1'b1;
  endtask

  // runaway guard: the run needs about 3025 cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 8000) begin
      num_errors++;
      print_verdict;
    end
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    reset_i    = 1'b1;
    num_errors = 0;
    tests_run  = 0;
    cycles     = 0;
    have_exp   = 1'b0;
    seed       = 32'h4A72FD6D;
    ts_nums    = '{5'h00, 5'h01, 5'h02, 5'h08, 5'h09, 5'h09, 5'h08, 5'h03};
    for (i = 0; i < 1024; i++) shadow[i] = 32'h0000_0000;
    repeat (16) @(negedge clk_i);
    reset_i = 1'b0;
    step(1'b1, 1'b0, 5'h09, 5'h0B, 32'h0, 1'b1, 1'b0, 1'b1);
    step(1'b1, 1'b1, 5'h09, 5'h0B, 32'hFFFF_FFFF, 1'b1, 1'b0, 1'b1);
    step(1'b1, 1'b0, 5'h09, 5'h0B, 32'h0, 1'b1, 1'b0, 1'b1);
    step(1'b1, 1'b0, 5'h09, 5'h0B, 32'h0, 1'b1, 1'b0, 1'b0);
    step(1'b1, 1'b1, 5'h10, 5'h0E, 32'h1234_5678, 1'b0, 1'b0, 1'b0);
    step(1'b1, 1'b0, 5'h10, 5'h0E, 32'h0, 1'b1, 1'b0, 1'b0);
    step(1'b1, 1'b0, 5'h01, 5'h0B, 32'h0, 1'b0, 1'b1, 1'b1);
    step(1'b1, 1'b1, 5'h17, 5'h0E, 32'hA5A5_0F0F, 1'b1, 1'b1, 1'b1);
    for (i = 0; i < 3000; i++) begin
      r = $random(seed);
      case (r[1:0])
        2'h0: rsel = 5'h0B;
        2'h1: rsel = 5'h0E;
        2'h2: rsel = 5'h0F;
        default: rsel = r[6:2];
      endcase
      rnum = (r[1:0] == 2'h0) ? ts_nums[r[9:7]] : r[14:10];
      step(r[23:21] != 3'h0, r[20], rnum, rsel, $random(seed), r[16] | r[17], r[18], r[19]);
    end
    step(1'b0, 1'b0, 5'h00, 5'h00, 32'h0, 1'b0, 1'b0, 1'b0);
    print_verdict;
  end
endmodule
